// >>> hdl/smc_pkg.sv
`default_nettype none
package smc_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] SYSCTL_IDX = 16'hffc4;
    localparam logic [15:0] MODERB_IDX = 16'hffc5;
    localparam int ADDR_W = 18;
    // system control layout and reset value
    localparam logic [7:0] SYSCTL_RST = 8'h09;
    localparam logic [7:0] SYSCTL_WMASK = 8'hf7;
    localparam int B_STANDBY_SELECT = 7;
    localparam int B_STS = 4;
    localparam int B_RESET_SOURCE_FLAG = 3;
    localparam int B_NMI_EDGE_SELECT = 2;
    localparam int B_HIE = 1;
    localparam int B_INTERNAL_RAM_ENABLE = 0;
    // mode readback fixed bits 7,6,5,2 read as one
    localparam logic [7:0] MODERB_FIXED = 8'he4;
    // mode pin codes {hi, lo}
    localparam logic [1:0] MODE_1 = 2'h1;
    localparam logic [1:0] MODE_2 = 2'h2;
    localparam logic [1:0] MODE_3 = 2'h3;
    // bus cycle lengths in states
    localparam logic [1:0] INT_STATES = 2'h2;
    localparam logic [1:0] EXT_STATES = 2'h3;
    // settling
    localparam int SETTLE_BASE_DEF = 8192;
    localparam logic [17:0] FAST_SETTLE = 18'h00400;
    localparam logic [2:0] STS_FAST = 3'h5;
    // address map
    localparam logic [15:0] ROM_HI = 16'h7fff;
    localparam logic [15:0] RAM_LO = 16'hfb80;
    localparam logic [15:0] RAM_HI = 16'hff7f;
    localparam logic [15:0] REG_LO = 16'hff88;
    typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_STBY, PWR_SETTLE} smc_pwr_t;
endpackage
`default_nettype wire

// >>> hdl/smc_top.sv
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module smc_top #(
    parameter int SETTLE_BASE = smc_pkg::SETTLE_BASE_DEF,
    parameter bit FLASH_PART = 1'b0
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [smc_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // pins
    input wire logic mode_pin_hi,
    input wire logic mode_pin_lo,
    input wire logic nmi_pin,
    // cpu and system events
    input wire logic wdt_reset,
    input wire logic sleep_req,
    input wire logic wake_irq,
    output logic nmi_req,
    // cpu access requests
    input wire logic acc_req,
    input wire logic [15:0] acc_addr,
    input wire logic acc_word,
    output logic acc_busy,
    output logic acc_done,
    output logic acc_ext,
    output logic [15:0] acc_ext_addr,
    // power and configuration outputs
    output logic cpu_halt,
    output logic sleep_mode,
    output logic standby_mode,
    output logic periph_reinit,
    output logic host_port_enable,
    output logic internal_ram_enable,
    output logic nmi_edge_select,
    output logic expanded_mode,
    output logic rom_enable,
    output logic ports_gpio
);

    // base << 4 must still fit the 18-bit settle counter
    if (SETTLE_BASE < 1 || SETTLE_BASE > 8192) begin : g_chk
        $error("SETTLE_BASE out of range");
    end

    typedef struct packed {
        logic [7:0] sysctl;
        logic [1:0] mode_latch;
        logic [31:0] rdata;
        logic hready;
        logic wr_pend;
        smc_pkg::smc_pwr_t pwr;
        logic [17:0] settle_cnt;
        logic halt;
        logic slp;
        logic stby;
        logic reinit;
        logic mhi_s1;
        logic mhi_s2;
        logic mlo_s1;
        logic mlo_s2;
        logic nmi_s1;
        logic nmi_s2;
        logic nmi_d;
        logic nmi_req;
        logic expd;
        logic rom_en;
        logic gpio;
        logic busy;
        logic [1:0] cnt;
        logic [1:0] len;
        logic second;
        logic word;
        logic ext;
        logic done;
        logic [15:0] addr;
    } smc_state_t;

    smc_state_t s;
    smc_state_t n;

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    logic take;
    logic [15:0] idx;
    logic [1:0] mode;
    logic in_ram;
    logic in_rom;
    logic take_int;
    logic [17:0] base;
    logic [17:0] settle_len;
    logic split;

    assign take = hsel && htrans[1] && hready;
    assign idx = haddr[smc_pkg::ADDR_W-1:2];
    assign mode = {s.mhi_s2, s.mlo_s2};
    // mode 3 keeps RAM on chip whatever the enable says
    assign in_ram = acc_addr >= smc_pkg::RAM_LO && acc_addr <= smc_pkg::RAM_HI
        && (s.sysctl[smc_pkg::B_INTERNAL_RAM_ENABLE] || !s.expd);
    assign in_rom = s.rom_en && acc_addr <= smc_pkg::ROM_HI;
    assign take_int = in_ram || in_rom;
    assign base = 18'(SETTLE_BASE);
    assign split = s.word && s.len == smc_pkg::EXT_STATES && !s.second;

    always_comb begin
        case (s.sysctl[6:4])
            3'h0: settle_len = base;
            3'h1: settle_len = base << 1;
            3'h2: settle_len = base << 2;
            3'h3: settle_len = base << 3;
            // unused 11x falls back to the longest setting, the safe side
            default: begin
                if (FLASH_PART && s.sysctl[6:4] == smc_pkg::STS_FAST) begin
                    settle_len = smc_pkg::FAST_SETTLE;
                end else begin
                    settle_len = base << 4;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        n = s;
        n.done = 1'b0;
        n.reinit = 1'b0;
        n.nmi_req = 1'b0;
        n.hready = 1'b1;
        // mode pins and nmi are asynchronous: two flops first
        n.mhi_s1 = mode_pin_hi;
        n.mhi_s2 = s.mhi_s1;
        n.mlo_s1 = mode_pin_lo;
        n.mlo_s2 = s.mlo_s1;
        n.nmi_s1 = nmi_pin;
        n.nmi_s2 = s.nmi_s1;
        n.nmi_d = s.nmi_s2;
        // 00 is never driven by the board, so it needs no decode
        n.expd = mode != smc_pkg::MODE_3;
        n.rom_en = mode != smc_pkg::MODE_1;
        n.gpio = mode == smc_pkg::MODE_3;
        if (s.nmi_s2 != s.nmi_d && s.nmi_s2 == s.sysctl[smc_pkg::B_NMI_EDGE_SELECT]) begin
            n.nmi_req = 1'b1;
        end

        // register write data phase
        if (s.wr_pend) begin
            n.sysctl = (hwdata[7:0] & smc_pkg::SYSCTL_WMASK)
                | (s.sysctl & ~smc_pkg::SYSCTL_WMASK);
        end
        n.wr_pend = 1'b0;
        if (take) begin
            n.rdata = 32'h0;
            if (hwrite) begin
                n.wr_pend = idx == smc_pkg::SYSCTL_IDX;
            end else if (idx == smc_pkg::SYSCTL_IDX) begin
                n.rdata = {24'h0, s.sysctl};
            end else if (idx == smc_pkg::MODERB_IDX) begin
                n.mode_latch = mode;
                n.rdata = {24'h0, smc_pkg::MODERB_FIXED | {6'h0, n.mode_latch}};
            end
        end

        // power states
        case (s.pwr)
            smc_pkg::PWR_RUN: begin
                if (sleep_req && s.sysctl[smc_pkg::B_STANDBY_SELECT]) begin
                    n.pwr = smc_pkg::PWR_STBY;
                    n.reinit = 1'b1;
                end else if (sleep_req) begin
                    n.pwr = smc_pkg::PWR_SLEEP;
                end
            end
            smc_pkg::PWR_SLEEP: begin
                if (wake_irq) begin
                    n.pwr = smc_pkg::PWR_RUN;
                end
            end
            smc_pkg::PWR_STBY: begin
                if (wake_irq) begin
                    n.pwr = smc_pkg::PWR_SETTLE;
                    n.settle_cnt = settle_len - 18'h1;
                end
            end
            smc_pkg::PWR_SETTLE: begin
                // still halted until the oscillator has settled
                if (s.settle_cnt == 18'h0) begin
                    n.pwr = smc_pkg::PWR_RUN;
                end else begin
                    n.settle_cnt = s.settle_cnt - 18'h1;
                end
            end
            default: n.pwr = smc_pkg::PWR_RUN;
        endcase
        n.halt = n.pwr != smc_pkg::PWR_RUN;
        n.slp = n.pwr == smc_pkg::PWR_SLEEP;
        n.stby = n.pwr == smc_pkg::PWR_STBY || n.pwr == smc_pkg::PWR_SETTLE;

        // bus cycle sequencer, one count per state; done marks the last state
        // ext stands through the done state and drops after it
        if (s.done) begin
            n.ext = 1'b0;
        end
        if (s.busy) begin
            if (split && s.cnt == s.len - 2'h1) begin
                n.second = 1'b1;
                n.cnt = 2'h0;
                n.addr = s.addr + 16'h1;
            end else if (!split && s.cnt == s.len - 2'h2) begin
                n.busy = 1'b0;
                n.done = 1'b1;
            end else begin
                n.cnt = s.cnt + 2'h1;
            end
        end else if (acc_req && !s.halt) begin
            n.busy = 1'b1;
            n.cnt = 2'h0;
            n.second = 1'b0;
            n.word = acc_word;
            n.addr = acc_addr;
            n.len = take_int ? smc_pkg::INT_STATES : smc_pkg::EXT_STATES;
            n.ext = !take_int && acc_addr < smc_pkg::REG_LO && s.expd;
        end

        if (wdt_reset) begin
            n.sysctl = smc_pkg::SYSCTL_RST & ~(8'h1 << smc_pkg::B_RESET_SOURCE_FLAG);
            n.pwr = smc_pkg::PWR_RUN;
            n.halt = 1'b0;
            n.slp = 1'b0;
            n.stby = 1'b0;
            n.busy = 1'b0;
            n.ext = 1'b0;
            n.done = 1'b0;
            n.wr_pend = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            s <= '0;
            s.sysctl <= smc_pkg::SYSCTL_RST;
            s.hready <= 1'b1;
            s.pwr <= smc_pkg::PWR_RUN;
            // nmi syncs start at the idle pin level so reset shows no false edge; mode syncs reset to 0
            s.nmi_s1 <= 1'b1;
            s.nmi_s2 <= 1'b1;
            s.nmi_d <= 1'b1;
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign hreadyout = s.hready;
    assign hrdata = s.rdata;
    assign hresp = s.wr_pend & 1'b0;
    assign nmi_req = s.nmi_req;
    assign acc_busy = s.busy;
    assign acc_done = s.done;
    assign acc_ext = s.ext;
    assign acc_ext_addr = s.addr;
    assign cpu_halt = s.halt;
    assign sleep_mode = s.slp;
    assign standby_mode = s.stby;
    assign periph_reinit = s.reinit;
    assign host_port_enable = s.sysctl[smc_pkg::B_HIE];
    assign internal_ram_enable = s.sysctl[smc_pkg::B_INTERNAL_RAM_ENABLE];
    assign nmi_edge_select = s.sysctl[smc_pkg::B_NMI_EDGE_SELECT];
    assign expanded_mode = s.expd;
    assign rom_enable = s.rom_en;
    assign ports_gpio = s.gpio;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    int_two_states_a: assert property (
        !s.busy && acc_req && !s.halt && take_int && !wdt_reset
        |=> !s.done ##1 s.done) else $error("internal access not two states");
    ext_byte_three_a: assert property (
        !s.busy && acc_req && !s.halt && !take_int && !acc_word && !wdt_reset
        ##1 !wdt_reset [*2] |=> s.done) else $error("byte access not three states");
    ext_word_six_a: assert property (
        !s.busy && acc_req && !s.halt && !take_int && acc_word && !wdt_reset
        ##1 !wdt_reset [*5] |-> !s.done ##1 s.done)
        else $error("word access not six states");
    stby_entry_a: assert property (
        s.pwr == smc_pkg::PWR_RUN && sleep_req && s.sysctl[7] && !wdt_reset
        |=> s.stby && s.halt && s.reinit) else $error("standby not entered");
    sleep_entry_a: assert property (
        s.pwr == smc_pkg::PWR_RUN && sleep_req && !s.sysctl[7] && !wdt_reset
        |=> s.slp && !s.stby) else $error("sleep not entered");
    settle_halt_a: assert property (
        s.pwr == smc_pkg::PWR_SETTLE |-> s.halt && !s.busy) else $error("run during settle");
    reset_source_flag_clear_a: assert property (
        wdt_reset |=> !s.sysctl[3] && s.sysctl[0]) else $error("watchdog reset flag");
    reset_source_flag_keep_a: assert property (
        s.wr_pend && !wdt_reset |=> s.sysctl[3] == $past(s.sysctl[3]))
        else $error("write changed reset flag");
    nmi_edge_a: assert property (
        s.nmi_req |-> $past(s.nmi_s2) == $past(s.sysctl[2])) else $error("wrong nmi edge");
    mode_latch_a: assert property (
        take && !hwrite && idx == smc_pkg::MODERB_IDX
        |=> s.rdata[1:0] == $past(mode) && s.rdata[7:2] == 6'h39)
        else $error("mode readback not latched");
    ram_redirect_a: assert property (
        !s.busy && acc_req && !s.halt && s.expd && !s.sysctl[0] && acc_addr >= 16'hfb80
        && acc_addr <= 16'hff7f && !wdt_reset |=> s.len == 2'h3 && s.ext)
        else $error("ram range not sent off chip");
    rst_value_a: assert property (@(posedge core_clk) disable iff (1'b0)
        !rst_b |=> s.sysctl == smc_pkg::SYSCTL_RST) else $error("reset value wrong");
    settle_code_a: assert property (
        s.pwr == smc_pkg::PWR_STBY && wake_irq && !wdt_reset && s.sysctl[6:4] == 3'h0
        |=> s.settle_cnt == 18'(SETTLE_BASE - 1)) else $error("settle length wrong");
    fast_settle_a: assert property (
        s.pwr == smc_pkg::PWR_STBY && wake_irq && !wdt_reset
        && s.sysctl[6:4] == smc_pkg::STS_FAST
        |=> s.settle_cnt == (FLASH_PART ? smc_pkg::FAST_SETTLE - 18'h1 : 18'(SETTLE_BASE * 16 - 1)))
        else $error("code 101 settle wrong");
    standby_select_keep_a: assert property (
        s.pwr == smc_pkg::PWR_SETTLE && s.settle_cnt == 18'h0 && s.sysctl[7] && !s.wr_pend
        && !wdt_reset |=> !s.halt && s.sysctl[7]) else $error("standby select lost");
    ram_keep_a: assert property (
        s.stby && !s.wr_pend && !wdt_reset |=> s.sysctl[0] == $past(s.sysctl[0]))
        else $error("ram enable lost in standby");
    sysctl_write_a: assert property (
        s.wr_pend && !wdt_reset
        |=> (s.sysctl & smc_pkg::SYSCTL_WMASK) == ($past(hwdata[7:0]) & smc_pkg::SYSCTL_WMASK))
        else $error("register write lost");

endmodule
`default_nettype wire

// >>> verification/smc_ext_board.sv
`timescale 1ns/10ps
`default_nettype none
module smc_ext_board #(
    parameter logic [1:0] MODE = 2'h2
) (
    // clock
    input wire logic core_clk,
    // expansion bus
    input wire logic acc_ext,
    input wire logic [15:0] acc_ext_addr,
    output logic [15:0] last_ext_addr,
    // straps
    output logic mode_pin_hi,
    output logic mode_pin_lo
);
    // straps never move while running; 00 would decode the same as mode 2
    assign mode_pin_hi = MODE[1];
    assign mode_pin_lo = MODE[0];
    // byte address of the latest off-chip cycle, for split checks
    always_ff @(posedge core_clk) begin
        if (acc_ext) begin
            last_ext_addr <= acc_ext_addr;
        end
    end
endmodule
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    typedef struct {logic [15:0] a; logic w; int n; logic e;} smc_row_t;
    localparam int SB = 4;
    localparam logic [17:0] A_SYS = {smc_pkg::SYSCTL_IDX, 2'b00};
    localparam logic [17:0] A_MODE = {smc_pkg::MODERB_IDX, 2'b00};
    localparam logic [17:0] A_BAD = {16'hffc6, 2'b00};
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [17:0] haddr = 18'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic nmi_pin = 1'b1;
    logic wdt_reset = 1'b0, sleep_req = 1'b0, wake_irq = 1'b0, acc_req = 1'b0, acc_word = 1'b0;
    logic [15:0] acc_addr = 16'h0;
    wire logic hreadyout, hresp, mode_pin_hi, mode_pin_lo, nmi_req, acc_busy, acc_done, acc_ext;
    wire logic cpu_halt, sleep_mode, standby_mode, periph_reinit, host_port_enable;
    wire logic internal_ram_enable, nmi_edge_select, expanded_mode, rom_enable, ports_gpio;
    wire logic [31:0] hrdata;
    wire logic [15:0] acc_ext_addr, last_ext_addr;
    int bad_count = 0, samples_checked = 0, cycles = 0, n, s;
    logic [31:0] rd;
    logic e;
    // mode 2 map: rom low, external at f000, ram fc00, registers ff90
    smc_row_t rows[7] = '{'{16'h0100, 1'b0, 2, 1'b0}, '{16'h0100, 1'b1, 2, 1'b0},
        '{16'hfc00, 1'b1, 2, 1'b0}, '{16'hff90, 1'b0, 3, 1'b0}, '{16'hff90, 1'b1, 6, 1'b0},
        '{16'hf000, 1'b0, 3, 1'b1}, '{16'hf000, 1'b1, 6, 1'b1}};

    always #10 core_clk = ~core_clk;

    smc_top #(.SETTLE_BASE(SB), .FLASH_PART(1'b0)) i_dut (.core_clk(core_clk), .rst_b(rst_b),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .mode_pin_hi(mode_pin_hi), .mode_pin_lo(mode_pin_lo),
        .nmi_pin(nmi_pin), .wdt_reset(wdt_reset), .sleep_req(sleep_req),
        .wake_irq(wake_irq), .nmi_req(nmi_req), .acc_req(acc_req), .acc_addr(acc_addr),
        .acc_word(acc_word), .acc_busy(acc_busy), .acc_done(acc_done), .acc_ext(acc_ext),
        .acc_ext_addr(acc_ext_addr), .cpu_halt(cpu_halt), .sleep_mode(sleep_mode),
        .standby_mode(standby_mode), .periph_reinit(periph_reinit),
        .host_port_enable(host_port_enable), .internal_ram_enable(internal_ram_enable),
        .nmi_edge_select(nmi_edge_select), .expanded_mode(expanded_mode),
        .rom_enable(rom_enable), .ports_gpio(ports_gpio));

    smc_ext_board #(.MODE(smc_pkg::MODE_2)) i_board (.core_clk(core_clk), .acc_ext(acc_ext),
        .acc_ext_addr(acc_ext_addr), .last_ext_addr(last_ext_addr),
        .mode_pin_hi(mode_pin_hi), .mode_pin_lo(mode_pin_lo));

    ////////////////////////////////////////////////////////////////
    task report_and_stop;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task bus(input logic w, input logic [17:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk(hresp, 1'b0);
        chk(hreadyout, 1'b1);
    endtask

    // counts states from take to the done pulse; 20 means never answered
    task acc(input logic [15:0] a, input logic w);
        acc_req <= 1'b1;
        acc_addr <= a;
        acc_word <= w;
        @(posedge core_clk);
        acc_req <= 1'b0;
        n = 0;
        e = 1'b0;
        do begin
            @(posedge core_clk);
            n++;
            e = e | acc_ext;
        end while (acc_done !== 1'b1 && n < 20);
    endtask

    task nmi(input logic lvl, input logic exp);
        nmi_pin <= lvl;
        e = 1'b0;
        repeat (6) begin
            @(posedge core_clk);
            e = e | nmi_req;
        end
        chk(e, exp);
    endtask

    task nap;
        sleep_req <= 1'b1;
        @(posedge core_clk);
        sleep_req <= 1'b0;
        e = 1'b0;
        repeat (2) begin
            @(posedge core_clk);
            e = e | periph_reinit;
        end
    endtask

    task wake;
        wake_irq <= 1'b1;
        @(posedge core_clk);
        wake_irq <= 1'b0;
        n = 0;
        while (cpu_halt !== 1'b0 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
    endtask

    task do_reset;
        rst_b <= 1'b0;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            $display("ERROR %0t timeout", $time);
            report_and_stop;
        end
    end

    initial begin
        do_reset;
        bus(1'b0, A_SYS, 8'h00);
        chk(rd, {24'h0, smc_pkg::SYSCTL_RST});
        bus(1'b0, A_MODE, 8'h00);
        chk(rd, {24'h0, smc_pkg::MODERB_FIXED | smc_pkg::MODE_2});
        chk({expanded_mode, rom_enable, ports_gpio}, 3'b110);
        bus(1'b0, A_BAD, 8'h00);
        chk(rd, 32'h0);
        bus(1'b1, A_MODE, 8'h00);
        bus(1'b0, A_MODE, 8'h00);
        chk(rd, {24'h0, smc_pkg::MODERB_FIXED | smc_pkg::MODE_2});
        foreach (rows[i]) begin
            acc(rows[i].a, rows[i].w);
            chk(n, rows[i].n);
            chk(e, rows[i].e);
            chk(acc_busy, 1'b0);
        end
        chk(last_ext_addr, 16'hf001);
        nmi(1'b0, 1'b1);
        nmi(1'b1, 1'b0);
        bus(1'b1, A_SYS, 8'h06);
        bus(1'b0, A_SYS, 8'h00);
        chk(rd, 32'h0e);
        chk({host_port_enable, internal_ram_enable, nmi_edge_select}, 3'b101);
        nmi(1'b0, 1'b0);
        nmi(1'b1, 1'b1);
        // ram range goes off chip once the enable is cleared
        acc(16'hfc00, 1'b0);
        chk({n[3:0], e}, 5'h7);
        bus(1'b1, A_SYS, 8'h01);
        nap;
        chk({sleep_mode, standby_mode, cpu_halt, e}, 4'b1010);
        wake;
        chk(n <= 2, 1'b1);
        for (int c = 0; c < 6; c++) begin
            bus(1'b1, A_SYS, 8'h81 | 8'(c << 4));
            nap;
            chk({sleep_mode, standby_mode, cpu_halt, e}, 4'b0111);
            acc(16'h0100, 1'b0);
            chk(n, 20);
            wake;
            s = SB << (c > 3 ? 4 : c);
            chk(n >= s && n <= s + 2, 1'b1);
            bus(1'b0, A_SYS, 8'h00);
            chk(rd, 32'h89 | 32'(c << 4));
        end
        bus(1'b1, A_SYS, 8'h01);
        bus(1'b0, A_SYS, 8'h00);
        chk(rd, 32'h09);
        wdt_reset <= 1'b1;
        @(posedge core_clk);
        wdt_reset <= 1'b0;
        @(posedge core_clk);
        bus(1'b0, A_SYS, 8'h00);
        chk(rd, 32'h01);
        do_reset;
        bus(1'b0, A_SYS, 8'h00);
        chk(rd, 32'h09);
        report_and_stop;
    end
endmodule
`default_nettype wire
